//--- design/arsp_host.sv
// host end of the converter serial port: reads the result, writes the control byte
// Notes on behaviour
// - host makes every serial clock edge; device is slave only
// - direction line low for control write, high for result read
// - chip select held low for the whole access
// - a read moves ten bits, or eight when the low two are unwanted
// - direction line stays high for the whole read
// - direction goes low then high before every new read
// - direction goes high then low before every further control write
// - chip select may stay low only when no other device shares the bus
// - data lines may be joined into one shared line, three wires total
// - three-wire: direction pulsed low then high before each read
// - three-wire: direction pulsed high then low before each write
`include "arsp_params.svh"
module arsp_host (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              three_wire,
    input  wire logic              keep_cs_low,
    input  wire logic              rd_start,
    input  wire logic              rd_short,
    input  wire logic              wr_start,
    input  wire logic [7:0]        wr_byte,
    output logic                   busy,
    output logic                   rd_done,
    output arsp_pkg::arsp_rsp_t    rd_rsp,
    output logic                   wr_done,
    output arsp_pkg::arsp_pins_t   pins,
    input  wire logic              din_pin
);
    arsp_pkg::arsp_state_t state_r;
    arsp_pkg::arsp_state_t state_nxt;
    logic       is_rd_r;
    logic       short_r;
    logic [3:0] bit_cnt_r;
    logic [2:0] div_r;
    logic [9:0] rx_r;
    logic [7:0] tx_r;
    logic       din_s1_r;
    logic       din_s2_r;
    logic       rd_done_r;
    logic       wr_done_r;
    logic       cs_n_r;
    logic       rd_wr_r;
    logic       sclk_r;
    logic       dout_r;
    logic       dout_oe_r;
    arsp_pkg::arsp_rsp_t rsp_r;

    wire        tick      = (div_r == 3'(`ARSP_SCLK_DIV - 1));
    wire [3:0]  need_bits = is_rd_r ? (short_r ? 4'(`ARSP_SHORT_BITS) : 4'(`ARSP_RESULT_BITS))
                                    : 4'(`ARSP_CTRL_BITS);
    wire        last_bit  = (bit_cnt_r == need_bits - 4'h1);
    wire        go_rd     = (state_r == arsp_pkg::ST_IDLE) && rd_start;
    wire        go_wr     = (state_r == arsp_pkg::ST_IDLE) && !rd_start && wr_start;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            arsp_pkg::ST_IDLE:  if (go_rd || go_wr) state_nxt = arsp_pkg::ST_SETUP;
            arsp_pkg::ST_SETUP: if (tick) state_nxt = arsp_pkg::ST_LOW;
            arsp_pkg::ST_LOW:   if (tick) state_nxt = arsp_pkg::ST_HIGH;
            arsp_pkg::ST_HIGH:  if (tick) state_nxt = last_bit ? arsp_pkg::ST_GAP : arsp_pkg::ST_LOW;
            arsp_pkg::ST_GAP:   if (tick) state_nxt = arsp_pkg::ST_IDLE;
            default:            state_nxt = arsp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= arsp_pkg::ST_IDLE;
            div_r   <= 3'h0;
        end else begin
            state_r <= state_nxt;
            div_r   <= (state_r == arsp_pkg::ST_IDLE || tick) ? 3'h0 : div_r + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            din_s1_r <= din_pin;
            din_s2_r <= din_s1_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            is_rd_r   <= 1'b0;
            short_r   <= 1'b0;
            bit_cnt_r <= 4'h0;
            rx_r      <= 10'h000;
            tx_r      <= 8'h00;
            cs_n_r    <= 1'b1;
            rd_wr_r   <= 1'b1;
            sclk_r    <= 1'b1;
            dout_r    <= 1'b0;
            dout_oe_r <= 1'b0;
            rd_done_r <= 1'b0;
            wr_done_r <= 1'b0;
            rsp_r     <= '0;
        end else begin
            rd_done_r <= 1'b0;
            wr_done_r <= 1'b0;
            case (state_r)
                arsp_pkg::ST_IDLE: begin
                    bit_cnt_r <= 4'h0;
                    if (go_rd || go_wr) begin
                        is_rd_r <= go_rd;
                        short_r <= rd_short;
                        tx_r    <= wr_byte;
                        cs_n_r  <= 1'b0;
                        // opposite level first, so every access gets its own direction edge
                        rd_wr_r <= !go_rd;
                    end else begin
                        cs_n_r  <= !keep_cs_low;
                    end
                end
                arsp_pkg::ST_SETUP: begin
                    // write data placed on the line; host drives it only when writing
                    rd_wr_r   <= is_rd_r;
                    dout_oe_r <= !is_rd_r;
                    dout_r    <= tx_r[7];
                    // first fall moves no data; it only arms the bit stream
                    if (tick) sclk_r <= 1'b0;
                end
                arsp_pkg::ST_LOW: begin
                    if (tick) begin
                        sclk_r <= 1'b1;
                        if (is_rd_r) rx_r <= {rx_r[8:0], din_s2_r};
                    end
                end
                arsp_pkg::ST_HIGH: begin
                    if (tick) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (last_bit) begin
                            rd_wr_r   <= !is_rd_r ? 1'b0 : 1'b1;
                            dout_oe_r <= 1'b0;
                        end else begin
                            sclk_r <= 1'b0;
                            tx_r   <= {tx_r[6:0], 1'b0};
                            dout_r <= tx_r[6];
                        end
                    end
                end
                arsp_pkg::ST_GAP: begin
                    if (tick) begin
                        rd_wr_r <= !is_rd_r;
                        cs_n_r  <= keep_cs_low ? 1'b0 : 1'b1;
                        if (is_rd_r) begin
                            rd_done_r   <= 1'b1;
                            rsp_r.full  <= !short_r;
                            rsp_r.result <= short_r ? {rx_r[7:0], 2'b00} : rx_r;
                        end else begin
                            wr_done_r <= 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    assign busy         = (state_r != arsp_pkg::ST_IDLE);
    assign rd_done      = rd_done_r;
    assign wr_done      = wr_done_r;
    assign rd_rsp       = rsp_r;
    assign pins.cs_n    = cs_n_r;
    assign pins.rd_wr   = rd_wr_r;
    assign pins.sclk    = sclk_r;
    assign pins.dout    = dout_r;
    assign pins.dout_oe = dout_oe_r;

    a_read_count: assert property (@(posedge clk) disable iff (rst)
        (state_r == arsp_pkg::ST_GAP && is_rd_r) |->
            (bit_cnt_r == (short_r ? 4'(`ARSP_SHORT_BITS) : 4'(`ARSP_RESULT_BITS))));
    a_cs_active: assert property (@(posedge clk) disable iff (rst)
        (state_r == arsp_pkg::ST_LOW) |-> !cs_n_r);
    a_dir_read: assert property (@(posedge clk) disable iff (rst)
        (state_r == arsp_pkg::ST_LOW && is_rd_r) |-> rd_wr_r);
    a_dir_write: assert property (@(posedge clk) disable iff (rst)
        (state_r == arsp_pkg::ST_LOW && !is_rd_r) |-> !rd_wr_r);
    a_no_drive_rd: assert property (@(posedge clk) disable iff (rst)
        (is_rd_r && state_r == arsp_pkg::ST_LOW) |-> !dout_oe_r);
    a_sclk_idle: assert property (@(posedge clk) disable iff (rst)
        (state_r == arsp_pkg::ST_IDLE) |-> sclk_r);
    a_wr_done_pulse: assert property (@(posedge clk) disable iff (rst)
        wr_done_r |=> !wr_done_r);
    a_dir_toggle: assert property (@(posedge clk) disable iff (rst)
        rd_done_r |-> !rd_wr_r);

    // direction lead-in: one cycle at the opposite level, then the access level
    sequence s_dir_low_high;
        !rd_wr_r ##1 rd_wr_r;
    endsequence
    sequence s_dir_high_low;
        rd_wr_r ##1 !rd_wr_r;
    endsequence
    a_read_lead: assert property (@(posedge clk) disable iff (rst)
        go_rd |=> s_dir_low_high) else $error("read started without a direction rise");
    a_write_lead: assert property (@(posedge clk) disable iff (rst)
        go_wr |=> s_dir_high_low) else $error("write started without a direction fall");
    a_sclk_steady: assert property (@(posedge clk) disable iff (rst)
        !tick |=> $stable(sclk_r)) else $error("serial clock moved off the divider tick");
    a_idle_cs: assert property (@(posedge clk) disable iff (rst)
        (state_r == arsp_pkg::ST_IDLE && !go_rd && !go_wr) |=> (cs_n_r == !$past(keep_cs_low)))
        else $error("idle chip select does not follow the hold setting");
    a_wr_drive: assert property (@(posedge clk) disable iff (rst)
        (state_r == arsp_pkg::ST_LOW && !is_rd_r) |-> dout_oe_r) else $error("write data not driven");
    a_short_zero: assert property (@(posedge clk) disable iff (rst)
        (rd_done_r && !rsp_r.full) |-> (rsp_r.result[1:0] == 2'b00))
        else $error("short read low bits not cleared");
endmodule : arsp_host

//--- common/arsp_params.svh
// timing constants and fixed counts for the serial port host
`ifndef ARSP_PARAMS_SVH
`define ARSP_PARAMS_SVH
`define ARSP_CLK_HZ        50000000
`define ARSP_SCLK_DIV      4
`define ARSP_RESULT_BITS   10
`define ARSP_SHORT_BITS    8
`define ARSP_CTRL_BITS     8
`define ARSP_GAP_NS        100
`define ARSP_GAP_CYC       ((`ARSP_GAP_NS * (`ARSP_CLK_HZ / 1000000) + 999) / 1000)
`define ARSP_TEMP_CHANNEL  3'h0
`endif

//--- common/arsp_pkg.sv
// types for the serial port host
package arsp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_GAP   = 3'b100
    } arsp_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_wr;
        logic       sclk;
        logic       dout;
        logic       dout_oe;
    } arsp_pins_t;

    typedef struct packed {
        logic [9:0] result;
        logic       full;
    } arsp_rsp_t;
endpackage : arsp_pkg

//--- testbench/arsp_dev_model.sv
// behavioural converter serial port answering the host
module arsp_dev_model (
    input  wire logic       three_wire,
    input  wire logic       cs_n,
    input  wire logic       rd_wr,
    input  wire logic       sclk,
    input  wire logic       host_d,
    input  wire logic       host_oe,
    input  wire logic [9:0] result,
    output logic            pin,
    output logic [7:0]      ctrl,
    output logic [3:0]      wcnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] idx = 4'hA;
    logic       first = 1'b0;
    logic       held = 1'b0;
    logic       drv;
    logic       val;
    wire        sel = three_wire | ~cs_n;
    wire        dev_oe = rd_wr & sel;
    wire        dev_bit = (idx < 4'hA) ? result[4'h9 - idx] : 1'b0;
    initial ctrl = 8'h00;
    initial wcnt = 4'h8;
    assign drv = (three_wire & host_oe) | dev_oe;
    assign val = (three_wire & host_oe) ? host_d : dev_bit;
    // released line shows the inverse of its last level
    always @* if (drv) held = val;
    assign pin = drv ? val : ~held;
    always @(posedge rd_wr) begin
        idx = 4'h0;
        first = 1'b1;
    end
    // only host clock edges move data; first fall keeps the top bit
    always @(negedge sclk) begin
        if (dev_oe && first) first = 1'b0;
        else if (dev_oe && idx < 4'hA) idx = idx + 4'h1;
    end
    always @(negedge rd_wr) wcnt = 4'h0;
    always @(posedge sclk) if (!rd_wr && sel && wcnt < 4'h8) begin
        ctrl = {ctrl[6:0], three_wire ? pin : host_d};
        wcnt = wcnt + 4'h1;
    end
endmodule : arsp_dev_model

//--- testbench/arsp_host_test.sv
// self-checking bench for the serial port host
module arsp_host_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic wr; logic full; logic [9:0] v;} arsp_exp_t;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 three_wire = 1'b0;
    logic                 keep_cs_low = 1'b0;
    logic                 rd_start = 1'b0;
    logic                 rd_short = 1'b0;
    logic                 wr_start = 1'b0;
    logic [7:0]           wr_byte = 8'h00;
    logic [9:0]           result = 10'h000;
    logic                 busy, rd_done, wr_done, din_pin;
    logic [7:0]           ctrl;
    arsp_pkg::arsp_rsp_t  rd_rsp;
    arsp_pkg::arsp_pins_t pins;
    arsp_exp_t            exp_q[$];
    arsp_exp_t            e;
    int                   bad_count = 0;
    int                   check_count = 0;
    int                   cycles = 0;
    always #10 clk = ~clk;
    arsp_host dut (.clk(clk), .rst(rst), .three_wire(three_wire), .keep_cs_low(keep_cs_low),
        .rd_start(rd_start), .rd_short(rd_short), .wr_start(wr_start), .wr_byte(wr_byte), .busy(busy),
        .rd_done(rd_done), .rd_rsp(rd_rsp), .wr_done(wr_done), .pins(pins), .din_pin(din_pin));
    arsp_dev_model dev (.three_wire(three_wire), .cs_n(pins.cs_n), .rd_wr(pins.rd_wr), .sclk(pins.sclk),
        .host_d(pins.dout), .host_oe(pins.dout_oe), .result(result), .pin(din_pin), .ctrl(ctrl), .wcnt());
    task automatic check(input string what, input logic [9:0] exp_v, input logic [9:0] got);
        check_count++;
        if (got !== exp_v) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp_v, got);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // one access, then a start while busy that must be ignored
    task automatic op(input logic wr, input logic full);
        @(posedge clk) #2;
        three_wire = $urandom;
        keep_cs_low = $urandom;
        rd_short = ~full;
        result = $urandom;
        wr_byte = $urandom;
        exp_q.push_back(wr ? {2'b11, 2'b00, wr_byte} : {1'b0, full, result});
        rd_start = ~wr;
        wr_start = wr;
        @(posedge clk) #2;
        rd_start = 1'b0;
        wr_start = 1'b0;
        repeat (3) @(posedge clk) #2;
        wr_start = 1'b1;
        @(posedge clk) #2;
        wr_start = 1'b0;
        while (busy !== 1'b0) @(posedge clk) #2;
    endtask : op
    always @(negedge clk) begin
        if (rd_done === 1'b1 || wr_done === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected done", 10'h000, 10'h001);
            else begin
                e = exp_q.pop_front();
                check("done kind", {9'h000, e.wr}, {9'h000, wr_done});
                if (e.wr) check("control byte", {2'b00, e.v[7:0]}, {2'b00, ctrl});
                else check("result", e.full ? e.v : {e.v[9:2], 2'b00}, rd_rsp.result);
                if (!e.wr) check("full flag", {9'h000, e.full}, {9'h000, rd_rsp.full});
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'hd4f3e052));
        repeat (8) @(posedge clk);
        #2 rst = 1'b0;
        for (int i = 0; i < 40; i++) op($urandom, $urandom);
        repeat (4) @(posedge clk);
        check("pending results", 10'h000, 10'(exp_q.size()));
        close_out();
    end
endmodule : arsp_host_test
